//--- src/ucs_dev.sv
// Device end: clock select for channel B and command interpreters for both channels.
// Assumes writes arrive on the interface one cycle each, already spaced by the host.
`timescale 1ns/1ps
module ucs_dev (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    ucs_if.dev              bus,
    input  wire logic [1:0] tx_idle_i,
    input  wire logic [1:0] mr_access_i,
    output logic      [1:0] rx_en_o,
    output logic      [1:0] tx_en_o,
    output logic      [1:0] tx_ready_flag_o,
    output logic      [1:0] tx_empty_flag_o,
    output logic      [1:0] rx_abort_o,
    output logic      [1:0] rx_search_o,
    output logic      [1:0] rx_reset_o,
    output logic      [1:0] tx_reset_o,
    output logic      [1:0] err_clr_o,
    output logic      [1:0] brk_chg_clr_o,
    output logic      [1:0] brk_on_o,
    output logic      [1:0] request_to_send_out_o,
    output logic      [1:0] timeout_mode_o,
    output logic      [1:0] ctr_stop_o,
    output logic      [3:0] mr_ptr_o,
    output logic            osc_run_o,
    output logic      [1:0] rx_b_src_o,
    output logic      [1:0] tx_b_src_o,
    output logic      [7:0] csb_o
);
    logic [7:0] csb_reg;
    logic [1:0] mrp_reg [2];
    logic       osc_reg;

    // Returns 0 for internal 16x, 1 for pin 16x, 2 for pin 1x.
    function automatic logic [1:0] ucs_csel(input logic [3:0] code);
        if (code == ucs_pkg::UCS_CSEL_PIN1) begin
            ucs_csel = 2'h2;
        end else if (code == ucs_pkg::UCS_CSEL_PIN16) begin
            ucs_csel = 2'h1;
        end else begin
            ucs_csel = 2'h0;
        end
    endfunction

    // Pointer step after an access.
    function automatic logic [1:0] ucs_mrp_step(input logic [1:0] p);
        ucs_mrp_step = (p == ucs_pkg::UCS_MRP_ZERO) ? ucs_pkg::UCS_MRP_ONE : ucs_pkg::UCS_MRP_TWO;
    endfunction

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            csb_reg <= ucs_pkg::UCS_CSB_RESET;
        end else if (bus.wr && bus.addr == ucs_pkg::UCS_ADDR_CSB) begin
            csb_reg <= bus.wdata;
        end
    end
    assign csb_o      = csb_reg;
    assign rx_b_src_o = ucs_csel(csb_reg[7:4]);
    assign tx_b_src_o = ucs_csel(csb_reg[3:0]);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_reg <= 1'b1;
        end else if (bus.wr && bus.addr == ucs_pkg::UCS_ADDR_CMD_A) begin
            if (bus.wdata[7:4] == ucs_pkg::UCS_MC_PD_ON) begin
                osc_reg <= 1'b0;
            end else if (bus.wdata[7:4] == ucs_pkg::UCS_MC_PD_OFF) begin
                osc_reg <= 1'b1;
            end
        end
    end
    assign osc_run_o = osc_reg;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic       hit;
            logic [3:0] mc;
            logic [3:0] lo;
            logic       cmd_ok;
            assign hit = bus.wr && (bus.addr == (ch == 0 ? ucs_pkg::UCS_ADDR_CMD_A
                                                          : ucs_pkg::UCS_ADDR_CMD_B));
            assign mc  = bus.wdata[7:4];
            assign lo  = bus.wdata[3:0];
            // Commands other than restart on channel A are ignored while the oscillator is stopped.
            assign cmd_ok = hit && (osc_reg || (ch == 0 && mc == ucs_pkg::UCS_MC_PD_OFF));

            // Receiver and transmitter enables; low and high nibble act together.
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    rx_en_o[ch] <= 1'b0;
                end else if (cmd_ok) begin
                    if (mc == ucs_pkg::UCS_MC_RX_RST || lo[ucs_pkg::UCS_BIT_RX_DIS]) begin
                        rx_en_o[ch] <= 1'b0;
                    end else if (lo[ucs_pkg::UCS_BIT_RX_EN]) begin
                        rx_en_o[ch] <= 1'b1;
                    end
                end
            end

            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    tx_en_o[ch]         <= 1'b0;
                    tx_ready_flag_o[ch] <= 1'b0;
                    tx_empty_flag_o[ch] <= 1'b0;
                end else if (cmd_ok) begin
                    if (mc == ucs_pkg::UCS_MC_TX_RST || lo[ucs_pkg::UCS_BIT_TX_DIS]) begin
                        tx_en_o[ch]         <= 1'b0;
                        tx_ready_flag_o[ch] <= 1'b0;
                        tx_empty_flag_o[ch] <= 1'b0;
                    end else if (lo[ucs_pkg::UCS_BIT_TX_EN]) begin
                        tx_en_o[ch] <= 1'b1;
                        if (tx_idle_i[ch]) begin
                            tx_ready_flag_o[ch] <= 1'b1;
                            tx_empty_flag_o[ch] <= 1'b1;
                        end
                    end
                end
            end

            // One-cycle command pulses.
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    rx_abort_o[ch]    <= 1'b0;
                    rx_search_o[ch]   <= 1'b0;
                    rx_reset_o[ch]    <= 1'b0;
                    tx_reset_o[ch]    <= 1'b0;
                    err_clr_o[ch]     <= 1'b0;
                    brk_chg_clr_o[ch] <= 1'b0;
                    ctr_stop_o[ch]    <= 1'b0;
                end else begin
                    rx_abort_o[ch]    <= cmd_ok && lo[ucs_pkg::UCS_BIT_RX_DIS];
                    rx_search_o[ch]   <= cmd_ok && lo[ucs_pkg::UCS_BIT_RX_EN];
                    rx_reset_o[ch]    <= cmd_ok && mc == ucs_pkg::UCS_MC_RX_RST;
                    tx_reset_o[ch]    <= cmd_ok && mc == ucs_pkg::UCS_MC_TX_RST;
                    err_clr_o[ch]     <= cmd_ok && (mc == ucs_pkg::UCS_MC_ERR_CLR
                                                    || mc == ucs_pkg::UCS_MC_RX_RST);
                    brk_chg_clr_o[ch] <= cmd_ok && mc == ucs_pkg::UCS_MC_BRK_CLR;
                    ctr_stop_o[ch]    <= cmd_ok && mc == ucs_pkg::UCS_MC_TO_ON;
                end
            end

            // Break, request-to-send and time-out mode levels.
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    brk_on_o[ch]              <= 1'b0;
                    request_to_send_out_o[ch] <= 1'b1;
                    timeout_mode_o[ch]        <= 1'b0;
                end else if (cmd_ok) begin
                    unique case (mc)
                        ucs_pkg::UCS_MC_BRK_ON:  brk_on_o[ch] <= tx_en_o[ch];
                        ucs_pkg::UCS_MC_BRK_OFF: brk_on_o[ch] <= 1'b0;
                        ucs_pkg::UCS_MC_TX_RST:  brk_on_o[ch] <= 1'b0;
                        ucs_pkg::UCS_MC_RTS_ON:  request_to_send_out_o[ch] <= 1'b0;
                        ucs_pkg::UCS_MC_RTS_OFF: request_to_send_out_o[ch] <= 1'b1;
                        ucs_pkg::UCS_MC_TO_ON:   timeout_mode_o[ch] <= 1'b1;
                        ucs_pkg::UCS_MC_TO_OFF:  timeout_mode_o[ch] <= 1'b0;
                        default: ;
                    endcase
                end
            end

            // Mode-register pointer.
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    mrp_reg[ch] <= ucs_pkg::UCS_MRP_ZERO;
                end else if (cmd_ok && mc == ucs_pkg::UCS_MC_MRP_ONE) begin
                    mrp_reg[ch] <= ucs_pkg::UCS_MRP_ONE;
                end else if (cmd_ok && mc == ucs_pkg::UCS_MC_MRP_ZERO) begin
                    mrp_reg[ch] <= ucs_pkg::UCS_MRP_ZERO;
                end else if (mr_access_i[ch]) begin
                    mrp_reg[ch] <= ucs_mrp_step(mrp_reg[ch]);
                end
            end
            assign mr_ptr_o[2*ch +: 2] = mrp_reg[ch];
        end
    endgenerate
endmodule

//--- src/ucs_pkg.sv
// Package of constants for the serial command and clock-select block.
// Assumes a single 200 MHz clock shared by both ends.
package ucs_pkg;
    localparam logic [3:0] UCS_ADDR_CSB   = 4'h1;
    localparam logic [3:0] UCS_ADDR_CMD_A = 4'h2;
    localparam logic [3:0] UCS_ADDR_CMD_B = 4'hA;
    localparam logic [3:0] UCS_OFS_CTRL   = 4'h0;
    localparam logic [3:0] UCS_OFS_STAT   = 4'h4;
    localparam logic [3:0] UCS_OFS_CSB    = 4'h8;
    localparam logic [3:0] UCS_OFS_CMDA   = 4'hC;
    localparam logic [3:0] UCS_OFS_CMDB   = 4'hD;
    localparam logic [3:0] UCS_CSEL_PIN16 = 4'hE;
    localparam logic [3:0] UCS_CSEL_PIN1  = 4'hF;
    localparam int UCS_BIT_RX_EN  = 0;
    localparam int UCS_BIT_RX_DIS = 1;
    localparam int UCS_BIT_TX_EN  = 2;
    localparam int UCS_BIT_TX_DIS = 3;
    localparam logic [3:0] UCS_MC_NONE     = 4'h0;
    localparam logic [3:0] UCS_MC_MRP_ONE  = 4'h1;
    localparam logic [3:0] UCS_MC_RX_RST   = 4'h2;
    localparam logic [3:0] UCS_MC_TX_RST   = 4'h3;
    localparam logic [3:0] UCS_MC_ERR_CLR  = 4'h4;
    localparam logic [3:0] UCS_MC_BRK_CLR  = 4'h5;
    localparam logic [3:0] UCS_MC_BRK_ON   = 4'h6;
    localparam logic [3:0] UCS_MC_BRK_OFF  = 4'h7;
    localparam logic [3:0] UCS_MC_RTS_ON   = 4'h8;
    localparam logic [3:0] UCS_MC_RTS_OFF  = 4'h9;
    localparam logic [3:0] UCS_MC_TO_ON    = 4'hA;
    localparam logic [3:0] UCS_MC_MRP_ZERO = 4'hB;
    localparam logic [3:0] UCS_MC_TO_OFF   = 4'hC;
    localparam logic [3:0] UCS_MC_PD_ON    = 4'hE;
    localparam logic [3:0] UCS_MC_PD_OFF   = 4'hF;
    localparam logic [1:0] UCS_MRP_ZERO = 2'h0;
    localparam logic [1:0] UCS_MRP_ONE  = 2'h1;
    localparam logic [1:0] UCS_MRP_TWO  = 2'h2;
    localparam logic [7:0] UCS_CSB_RESET = 8'h00;
    localparam logic [1:0] UCS_GAP_EDGES = 2'h3;
endpackage

//--- src/ucs_if.sv
// Interface carrying register writes from the host end to the device end.
// Assumes both ends share clk_i.
`timescale 1ns/1ps
interface ucs_if;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
    modport dev  (input wr, input addr, input wdata);
    modport host (output wr, output addr, output wdata);
endinterface

//--- src/ucs_host.sv
// Host end: turns software port writes into spaced device register writes.
// Assumes software uses the plain address, data and strobe port on clk_i.
`timescale 1ns/1ps
module ucs_host (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    ucs_if.host             bus,
    input  wire logic [3:0] sw_addr_i,
    input  wire logic [7:0] sw_wdata_i,
    input  wire logic       sw_wr_i,
    input  wire logic       sw_rd_i,
    output logic      [7:0] sw_rdata_o
);
    logic [7:0] cmda_reg;
    logic [7:0] cmdb_reg;
    logic [7:0] csb_reg;
    logic       pend_reg;
    logic [3:0] paddr_reg;
    logic [7:0] pdata_reg;
    logic [1:0] gap_reg;
    logic       is_dev;
    logic       is_cmd;
    logic       go;

    assign is_dev = sw_addr_i == ucs_pkg::UCS_OFS_CSB || sw_addr_i == ucs_pkg::UCS_OFS_CMDA
                    || sw_addr_i == ucs_pkg::UCS_OFS_CMDB;
    // A queued upper-nibble command leaves when the spacing since the last one is met; csb and lower-nibble-only writes leave at once.
    assign go = pend_reg && (gap_reg == 2'h0 || paddr_reg == ucs_pkg::UCS_ADDR_CSB
                             || pdata_reg[7:4] == ucs_pkg::UCS_MC_NONE);
    assign is_cmd = (paddr_reg != ucs_pkg::UCS_ADDR_CSB)
                    && pdata_reg[7:4] != ucs_pkg::UCS_MC_NONE;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_reg  <= 1'b0;
            paddr_reg <= 4'h0;
            pdata_reg <= 8'h00;
        end else if (sw_wr_i && is_dev && !pend_reg) begin
            pend_reg  <= 1'b1;
            paddr_reg <= (sw_addr_i == ucs_pkg::UCS_OFS_CSB) ? ucs_pkg::UCS_ADDR_CSB :
                         (sw_addr_i == ucs_pkg::UCS_OFS_CMDA) ? ucs_pkg::UCS_ADDR_CMD_A :
                         ucs_pkg::UCS_ADDR_CMD_B;
            pdata_reg <= sw_wdata_i;
        end else if (go) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_reg <= 2'h0;
        end else if (go && is_cmd) begin
            gap_reg <= ucs_pkg::UCS_GAP_EDGES;
        end else if (gap_reg != 2'h0) begin
            gap_reg <= gap_reg - 2'h1;
        end
    end

    assign bus.wr    = go;
    assign bus.addr  = paddr_reg;
    assign bus.wdata = pdata_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmda_reg <= 8'h00;
            cmdb_reg <= 8'h00;
            csb_reg  <= ucs_pkg::UCS_CSB_RESET;
        end else if (sw_wr_i && !pend_reg) begin
            if (sw_addr_i == ucs_pkg::UCS_OFS_CMDA) begin
                cmda_reg <= sw_wdata_i;
            end
            if (sw_addr_i == ucs_pkg::UCS_OFS_CMDB) begin
                cmdb_reg <= sw_wdata_i;
            end
            if (sw_addr_i == ucs_pkg::UCS_OFS_CSB) begin
                csb_reg <= sw_wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_rdata_o <= 8'h00;
        end else if (sw_rd_i) begin
            unique case (sw_addr_i)
                ucs_pkg::UCS_OFS_STAT: sw_rdata_o <= {6'h00, gap_reg != 2'h0, pend_reg};
                ucs_pkg::UCS_OFS_CSB:  sw_rdata_o <= csb_reg;
                ucs_pkg::UCS_OFS_CMDA: sw_rdata_o <= cmda_reg;
                ucs_pkg::UCS_OFS_CMDB: sw_rdata_o <= cmdb_reg;
                default:               sw_rdata_o <= 8'h00;
            endcase
        end else begin
            sw_rdata_o <= 8'h00;
        end
    end
endmodule

//--- verification/ucs_assertions.sv
// Checker over the command bus and the device outputs, channel A in bit 0.
// Assumes the bench hands it the interface signals and the device outputs.
`timescale 1ns/1ps
module ucs_assertions (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wr,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [1:0] tx_idle_i,
    input wire logic [1:0] rx_en_o,
    input wire logic [1:0] tx_en_o,
    input wire logic [1:0] tx_ready_flag_o,
    input wire logic [1:0] tx_empty_flag_o,
    input wire logic [1:0] rx_abort_o,
    input wire logic [1:0] rx_search_o,
    input wire logic [1:0] rx_reset_o,
    input wire logic [1:0] tx_reset_o,
    input wire logic [1:0] err_clr_o,
    input wire logic [1:0] brk_chg_clr_o,
    input wire logic [1:0] ctr_stop_o,
    input wire logic [1:0] timeout_mode_o,
    input wire logic [1:0] request_to_send_out_o,
    input wire logic       osc_run_o,
    input wire logic [1:0] rx_b_src_o,
    input wire logic [1:0] tx_b_src_o,
    input wire logic [7:0] csb_o
);
    logic misc_w;
    assign misc_w = wr && wdata[7:4] != 4'h0
        && (addr == ucs_pkg::UCS_ADDR_CMD_A || addr == ucs_pkg::UCS_ADDR_CMD_B);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_cmd_a;
        wr && addr == ucs_pkg::UCS_ADDR_CMD_A && osc_run_o;
    endsequence
    sequence s_misc;
        misc_w;
    endsequence
    misc_spacing_a: assert property (s_misc |=> (!misc_w) [*2])
        else $error("miscellaneous commands closer than three edges");
    tx_off_a: assert property (s_cmd_a ##0 wdata[3] |=>
        !tx_en_o[0] && !tx_ready_flag_o[0] && !tx_empty_flag_o[0]) else $error("tx not off");
    tx_on_a: assert property (s_cmd_a ##0 (wdata[2] && !wdata[3] && tx_idle_i[0]) |=>
        tx_en_o[0] && tx_ready_flag_o[0] && tx_empty_flag_o[0]) else $error("tx not on");
    rx_off_a: assert property (s_cmd_a ##0 wdata[1] |=>
        !rx_en_o[0] && rx_abort_o[0] ##1 !rx_abort_o[0]) else $error("rx not stopped");
    rx_on_a: assert property (s_cmd_a ##0 (wdata[0] && !wdata[1]) |=>
        rx_en_o[0] && rx_search_o[0]) else $error("rx not searching");
    rx_reset_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'h2 |=>
        rx_reset_o[0] && !rx_en_o[0]) else $error("rx reset missing");
    tx_reset_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'h3 |=>
        tx_reset_o[0] && !tx_en_o[0]) else $error("tx reset missing");
    err_clr_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'h4 |=> err_clr_o[0])
        else $error("error clear missing");
    brk_chg_clr_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'h5 |=> brk_chg_clr_o[0])
        else $error("break change clear missing");
    ctr_stop_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'hA |=>
        ctr_stop_o[0] && timeout_mode_o[0]) else $error("time-out mode not entered");
    timeout_off_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'hC |=>
        !timeout_mode_o[0] && !ctr_stop_o[0]) else $error("time-out mode not left");
    rts_low_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'h8 |=>
        !request_to_send_out_o[0]) else $error("request to send not low");
    rts_high_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'h9 |=>
        request_to_send_out_o[0]) else $error("request to send not high");
    osc_stop_a: assert property (s_cmd_a ##0 wdata[7:4] == 4'hE |=> !osc_run_o)
        else $error("oscillator still running");
    chan_b_pd_a: assert property (wr && addr == ucs_pkg::UCS_ADDR_CMD_B
        && wdata[7:5] == 3'h7 |=> osc_run_o == $past(osc_run_o)) else $error("b power change");
    rx_clk_sel_a: assert property (rx_b_src_o == (csb_o[7:4] == 4'hE ? 2'h1
        : csb_o[7:4] == 4'hF ? 2'h2 : 2'h0)) else $error("rx clock source wrong");
    tx_clk_sel_a: assert property (tx_b_src_o == (csb_o[3:0] == 4'hE ? 2'h1
        : csb_o[3:0] == 4'hF ? 2'h2 : 2'h0)) else $error("tx clock source wrong");
endmodule

//--- verification/uart_command_clock_select_tb_top.sv
// Testbench joining host and device ends; drives the software port.
// Assumes the host reports a pending write in status bit 0.
`timescale 1ns/1ps
module uart_command_clock_select_tb_top;
    logic       clk_i;
    logic       rst_i;
    logic [3:0] sw_addr_i;
    logic [7:0] sw_wdata_i, sw_rdata_o, csb_o, rd;
    logic       sw_wr_i, sw_rd_i, osc_run_o;
    logic [1:0] tx_idle_i, mr_access_i, rx_en_o, tx_en_o, tx_ready_flag_o, tx_empty_flag_o;
    logic [1:0] rx_abort_o, rx_search_o, rx_reset_o, brk_on_o, request_to_send_out_o;
    logic [1:0] timeout_mode_o, rx_b_src_o, tx_b_src_o;
    logic [3:0] mr_ptr_o;
    logic [1:0] tx_reset_o, err_clr_o, brk_chg_clr_o, ctr_stop_o;
    int         num_errors = 0;
    int         n_checks = 0;
    logic [3:0] csel [3] = '{4'hE, 4'hF, 4'h3};
    logic [1:0] src  [3] = '{2'h1, 2'h2, 2'h0};
    logic [7:0] mcmd [12] = '{8'h84, 8'h60, 8'h70, 8'h90, 8'hA0, 8'hC0,
                              8'hB0, 8'h10, 8'h00, 8'hD0, 8'h08, 8'h60};
    logic [7:0] mexp [12] = '{8'h02, 8'h12, 8'h02, 8'h0A, 8'h0E, 8'h0A,
                              8'h08, 8'h09, 8'h09, 8'h09, 8'h09, 8'h09};
    ucs_if bus_if ();
    ucs_host i_ucs_host (.clk_i, .rst_i, .bus(bus_if.host), .sw_addr_i, .sw_wdata_i,
        .sw_wr_i, .sw_rd_i, .sw_rdata_o);
    ucs_dev i_ucs_dev (.clk_i, .rst_i, .bus(bus_if.dev), .tx_idle_i, .mr_access_i, .rx_en_o,
        .tx_en_o, .tx_ready_flag_o, .tx_empty_flag_o, .rx_abort_o, .rx_search_o, .rx_reset_o,
        .tx_reset_o, .err_clr_o, .brk_chg_clr_o, .brk_on_o, .request_to_send_out_o,
        .timeout_mode_o, .ctr_stop_o, .mr_ptr_o, .osc_run_o, .rx_b_src_o, .tx_b_src_o, .csb_o);
    ucs_assertions i_ucs_assertions (.clk_i, .rst_i, .wr(bus_if.wr), .addr(bus_if.addr),
        .wdata(bus_if.wdata), .tx_idle_i, .rx_en_o, .tx_en_o, .tx_ready_flag_o,
        .tx_empty_flag_o, .rx_abort_o, .rx_search_o, .rx_reset_o, .tx_reset_o, .err_clr_o,
        .brk_chg_clr_o, .ctr_stop_o, .timeout_mode_o, .request_to_send_out_o,
        .osc_run_o, .rx_b_src_o, .tx_b_src_o, .csb_o);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        sw_addr_i <= a;
        sw_rd_i   <= 1'b1;
        @(posedge clk_i);
        sw_rd_i <= 1'b0;
        #1;
        d = sw_rdata_o;
    endtask
    task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] st;
        @(posedge clk_i);
        sw_addr_i  <= a;
        sw_wdata_i <= d;
        sw_wr_i    <= 1'b1;
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
        st = 8'h01;
        for (int i = 0; i < 20 && st[0] !== 1'b0; i++) begin
            sw_read(ucs_pkg::UCS_OFS_STAT, st);
        end
        chk("write pending", 8'h00, {7'h00, st[0]});
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        num_errors++;
        summarize();
    end
    initial begin
        rst_i = 1'b1;
        {sw_addr_i, sw_wdata_i, sw_wr_i, sw_rd_i, mr_access_i} = '0;
        tx_idle_i = 2'h3;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk("rts reset", 8'h03, {6'h00, request_to_send_out_o});
        chk("osc reset", 8'h01, {7'h00, osc_run_o});
        chk("csb reset", ucs_pkg::UCS_CSB_RESET, csb_o);
        chk("mr ptr reset", 8'h00, {4'h0, mr_ptr_o});
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            mr_access_i <= 2'h1;
            @(posedge clk_i);
            mr_access_i <= 2'h0;
            #1;
            chk("mr ptr step", (i == 0) ? 8'h01 : 8'h02, {4'h0, mr_ptr_o});
        end
        $display("test reset and pointer done");
        for (int i = 0; i < 3; i++) begin
            sw_write(ucs_pkg::UCS_OFS_CSB, {csel[i], csel[2 - i]});
            chk("rx clock source", {6'h00, src[i]}, {6'h00, rx_b_src_o});
            chk("tx clock source", {6'h00, src[2 - i]}, {6'h00, tx_b_src_o});
            sw_read(ucs_pkg::UCS_OFS_CSB, rd);
            chk("csb readback", {csel[i], csel[2 - i]}, rd);
        end
        $display("test clock select done");
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h05);
        chk("rx on", 8'h01, {7'h00, rx_en_o[0]});
        chk("tx on", 8'h07, {5'h00, tx_en_o[0], tx_ready_flag_o[0], tx_empty_flag_o[0]});
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h0A);
        chk("rx off", 8'h00, {7'h00, rx_en_o[0]});
        chk("tx off", 8'h00, {5'h00, tx_en_o[0], tx_ready_flag_o[0], tx_empty_flag_o[0]});
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h01);
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h20);
        chk("rx reset", 8'h00, {7'h00, rx_en_o[0]});
        @(posedge clk_i);
        tx_idle_i <= 2'h0;
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h04);
        chk("tx busy", 8'h04, {5'h00, tx_en_o[0], tx_ready_flag_o[0], tx_empty_flag_o[0]});
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h30);
        chk("tx rst", 8'h00, {5'h00, tx_en_o[0], tx_ready_flag_o[0], tx_empty_flag_o[0]});
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h40);
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'h50);
        sw_read(ucs_pkg::UCS_OFS_CMDA, rd);
        chk("cmd a readback", 8'h50, rd);
        @(posedge clk_i);
        tx_idle_i <= 2'h3;
        $display("test enables done");
        for (int i = 0; i < 12; i++) begin
            sw_write(ucs_pkg::UCS_OFS_CMDA, mcmd[i]);
            chk("misc state", mexp[i], {3'h0, brk_on_o[0], request_to_send_out_o[0],
                timeout_mode_o[0], mr_ptr_o[1:0]});
        end
        $display("test misc commands done");
        sw_write(ucs_pkg::UCS_OFS_CMDB, 8'h85);
        chk("b command", 8'h06, {5'h00, rx_en_o[1], tx_en_o[1], request_to_send_out_o[1]});
        sw_read(ucs_pkg::UCS_OFS_CMDB, rd);
        chk("cmd b readback", 8'h85, rd);
        sw_write(ucs_pkg::UCS_OFS_CMDB, 8'hE0);
        chk("b power down", 8'h01, {7'h00, osc_run_o});
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'hE0);
        chk("a power down", 8'h00, {7'h00, osc_run_o});
        sw_write(ucs_pkg::UCS_OFS_CMDA, 8'hF0);
        chk("a power up", 8'h01, {7'h00, osc_run_o});
        $display("test power down done");
        summarize();
    end
endmodule
